// *** core/ieau_consts.vh ***
`ifndef IEAU_CONSTS_VH
`define IEAU_CONSTS_VH
// Base register select codes
`define IEAU_BASE_X      2'b00
`define IEAU_BASE_Y      2'b01
`define IEAU_BASE_SP     2'b10
`define IEAU_BASE_PC     2'b11
// Postbyte field positions
`define IEAU_PB_RR_HI    4
`define IEAU_PB_RR_LO    3
`define IEAU_PB_AUTO_RR_HI 7
`define IEAU_PB_AUTO_RR_LO 6
`define IEAU_PB_AUTO_BIT 5
`define IEAU_PB_TIMING   4
`define IEAU_PB_ACC_BIT  2
`define IEAU_PB_SIZE     1
`define IEAU_PB_SIGN     0
// Top three postbyte bits of the long/accumulator forms
`define IEAU_PB_LONG_TAG 3'b111
// Accumulator select codes
`define IEAU_ACC_A       2'b00
`define IEAU_ACC_B       2'b01
`define IEAU_ACC_D       2'b10
`define IEAU_ACC_DIND    2'b11
// Address-compute kinds
`define IEAU_KIND_NONE   3'd0
`define IEAU_KIND_OFS    3'd1
`define IEAU_KIND_IND    3'd2
`define IEAU_KIND_AUTO   3'd3
`define IEAU_KIND_ACC    3'd4
// Reset values
`define IEAU_RST_ADDR    16'h0000
`endif

// *** core/ieau_decode.v ***
`include "ieau_consts.vh"
// Combinational postbyte decode and address sum
module ieau_decode (
    input  wire [7:0]  indexed_postbyte_i,
    input  wire [7:0]  ext_hi_i,
    input  wire [7:0]  ext_lo_i,
    input  wire [15:0] x_i,
    input  wire [15:0] y_i,
    input  wire [15:0] sp_i,
    input  wire [15:0] pc_next_i,
    input  wire [7:0]  acc_a_i,
    input  wire [7:0]  acc_b_i,
    output reg  [2:0]  kind_o,
    output reg  [1:0]  base_sel_o,
    output reg  [15:0] sum_o,
    output reg  [15:0] access_o,
    output reg  [15:0] wb_o,
    output reg         wb_en_o
);
    reg  [7:0]  pb;
    reg  [15:0] base;
    reg  [15:0] step;
    reg  [15:0] ofs;
    reg  [1:0]  rr;

    function [15:0] sel_base;
        input [1:0]  sel;
        input [15:0] vx;
        input [15:0] vy;
        input [15:0] vs;
        input [15:0] vp;
        begin
            case (sel)
                `IEAU_BASE_X:  sel_base = vx;
                `IEAU_BASE_Y:  sel_base = vy;
                `IEAU_BASE_SP: sel_base = vs;
                default:       sel_base = vp;
            endcase
        end
    endfunction

    always @* begin
        pb       = indexed_postbyte_i;
        kind_o   = `IEAU_KIND_NONE;
        rr       = pb[`IEAU_PB_RR_HI:`IEAU_PB_RR_LO];
        ofs      = 16'h0000;
        step     = 16'h0000;
        wb_en_o  = 1'b0;
        base     = 16'h0000;
        sum_o    = 16'h0000;
        access_o = 16'h0000;
        wb_o     = 16'h0000;
        if (pb[7:5] == `IEAU_PB_LONG_TAG) begin
            base = sel_base(rr, x_i, y_i, sp_i, pc_next_i);
            if (!pb[`IEAU_PB_ACC_BIT]) begin
                if (!pb[`IEAU_PB_SIZE]) begin
                    kind_o = `IEAU_KIND_OFS;
                    ofs = {{8{pb[`IEAU_PB_SIGN]}}, ext_lo_i};
                end else begin
                    kind_o = pb[`IEAU_PB_SIGN] ? `IEAU_KIND_IND : `IEAU_KIND_OFS;
                    ofs = {ext_hi_i, ext_lo_i};
                end
            end else begin
                case (pb[1:0])
                    `IEAU_ACC_A: ofs = {8'h00, acc_a_i};
                    `IEAU_ACC_B: ofs = {8'h00, acc_b_i};
                    default:     ofs = {acc_a_i, acc_b_i};
                endcase
                kind_o = (pb[1:0] == `IEAU_ACC_DIND) ? `IEAU_KIND_IND : `IEAU_KIND_ACC;
            end
            sum_o    = base + ofs;
            access_o = sum_o;
        end else if (pb[`IEAU_PB_AUTO_BIT]) begin
            rr = pb[`IEAU_PB_AUTO_RR_HI:`IEAU_PB_AUTO_RR_LO];
            base = sel_base(rr, x_i, y_i, sp_i, pc_next_i);
            if (rr != `IEAU_BASE_PC) begin
                kind_o  = `IEAU_KIND_AUTO;
                // Step code 0000 is +1, 1000 is -8
                step = pb[3] ? {{12{1'b1}}, pb[3:0]} : {12'h000, pb[3:0]} + 16'h0001;
                sum_o   = base + step;
                access_o = pb[`IEAU_PB_TIMING] ? base : sum_o;
                wb_o    = sum_o;
                wb_en_o = 1'b1;
            end
        end
        base_sel_o = rr;
    end
endmodule

// *** core/ieau_top.v ***
// Functional notes
// - Nine-bit signed offset added to base
// - Sign from postbyte, low byte from extension
// - Constant offset leaves base register unchanged
// - Sixteen-bit offset is plain wrapping sum
// - Sixteen-bit offset from two extension bytes
// - Constant indirect reads pointer at sum
// - Auto-modify only on index registers, SP
// - Pre-modify updates base, uses new value
// - Post-modify uses old, then writes back
// - Step is minus eight..minus one, one..eight
// - Load-address to same register keeps access
// - Accumulator offset unsigned, nothing modified
// - Any base with A, B or D
// - D indirect fetches pointer at sum
// - Select 00 X, 01 Y, 10 SP, 11 PC
// - Size bit clear selects nine-bit offset
// - Timing bit zero pre, one post
// - PC base is next instruction address
`include "ieau_consts.vh"
module ieau_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        start_i,
    input  wire [7:0]  indexed_postbyte_i,
    input  wire [7:0]  ext_hi_i,
    input  wire [7:0]  ext_lo_i,
    input  wire [15:0] x_i,
    input  wire [15:0] y_i,
    input  wire [15:0] sp_i,
    input  wire [15:0] pc_next_i,
    input  wire [7:0]  acc_a_i,
    input  wire [7:0]  acc_b_i,
    input  wire        load_first_index_effective_address_i,
    input  wire        load_second_index_effective_address_i,
    input  wire        load_stack_pointer_effective_address_i,
    input  wire        mem_rdy_i,
    input  wire [7:0]  mem_rdata_i,
    output reg         mem_rd_o,
    output reg  [15:0] mem_addr_o,
    output reg         busy_o,
    output reg         done_o,
    output reg  [15:0] ea_o,
    output reg         wb_en_o,
    output reg  [1:0]  wb_sel_o,
    output reg  [15:0] wb_data_o,
    output reg         illegal_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_PHI  = 2'd1;
    localparam ST_PLO  = 2'd2;

    wire [2:0]  kind;
    wire [1:0]  base_sel;
    wire [15:0] sum;
    wire [15:0] access;
    wire [15:0] wb_val;
    wire        wb_req;
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [7:0]  ptr_hi_r;
    reg         lea_same;

    ieau_decode u_dec (
        .indexed_postbyte_i (indexed_postbyte_i),
        .ext_hi_i           (ext_hi_i),
        .ext_lo_i           (ext_lo_i),
        .x_i                (x_i),
        .y_i                (y_i),
        .sp_i               (sp_i),
        .pc_next_i          (pc_next_i),
        .acc_a_i            (acc_a_i),
        .acc_b_i            (acc_b_i),
        .kind_o             (kind),
        .base_sel_o         (base_sel),
        .sum_o              (sum),
        .access_o           (access),
        .wb_o               (wb_val),
        .wb_en_o            (wb_req)
    );

    always @* begin
        case (base_sel)
            `IEAU_BASE_X:  lea_same = load_first_index_effective_address_i;
            `IEAU_BASE_Y:  lea_same = load_second_index_effective_address_i;
            `IEAU_BASE_SP: lea_same = load_stack_pointer_effective_address_i;
            default:       lea_same = 1'b0;
        endcase
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_i && kind == `IEAU_KIND_IND) begin
                    state_nxt = ST_PHI;
                end
            end
            ST_PHI: begin
                if (mem_rdy_i) begin
                    state_nxt = ST_PLO;
                end
            end
            ST_PLO: begin
                if (mem_rdy_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= ST_IDLE;
            ptr_hi_r   <= 8'h00;
            mem_rd_o   <= 1'b0;
            mem_addr_o <= `IEAU_RST_ADDR;
            busy_o     <= 1'b0;
            done_o     <= 1'b0;
            ea_o       <= `IEAU_RST_ADDR;
            wb_en_o    <= 1'b0;
            wb_sel_o   <= 2'b00;
            wb_data_o  <= `IEAU_RST_ADDR;
            illegal_o  <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            done_o    <= 1'b0;
            wb_en_o   <= 1'b0;
            illegal_o <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start_i) begin
                        if (kind == `IEAU_KIND_IND) begin
                            // Pointer high byte at the lower address
                            mem_rd_o   <= 1'b1;
                            mem_addr_o <= sum;
                            busy_o     <= 1'b1;
                        end else if (kind == `IEAU_KIND_NONE) begin
                            illegal_o <= 1'b1;
                            done_o    <= 1'b1;
                        end else begin
                            ea_o    <= access;
                            done_o  <= 1'b1;
                            wb_sel_o <= base_sel;
                            // Post-modify dropped when a load-address targets the same register
                            if (wb_req) begin
                                wb_en_o   <= 1'b1;
                                wb_data_o <= lea_same ? access : wb_val;
                            end
                        end
                    end
                end
                ST_PHI: begin
                    if (mem_rdy_i) begin
                        ptr_hi_r   <= mem_rdata_i;
                        mem_addr_o <= mem_addr_o + 16'h0001;
                    end
                end
                ST_PLO: begin
                    if (mem_rdy_i) begin
                        mem_rd_o <= 1'b0;
                        busy_o   <= 1'b0;
                        ea_o     <= {ptr_hi_r, mem_rdata_i};
                        done_o   <= 1'b1;
                    end
                end
                default: begin
                    mem_rd_o <= 1'b0;
                    busy_o   <= 1'b0;
                end
            endcase
        end
    end
endmodule

// *** tb/ieau_mem.sv ***
module ieau_mem (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [3:0]  lat_i,
    output logic             rdy_o,
    output logic [7:0]       data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    // Never two answers in a row, so the requester must step its address
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdy_o  <= 1'b0;
            data_o <= 8'h5a;
            cnt_r  <= 4'h0;
        end else if (rd_i && !rdy_o && cnt_r == lat_i) begin
            rdy_o  <= 1'b1;
            // Neighbouring bytes differ, so a swapped pointer pair shows up
            data_o <= addr_i[15:8] + {addr_i[6:0], 1'b1};
            cnt_r  <= 4'h0;
        end else begin
            rdy_o  <= 1'b0;
            data_o <= ~data_o;
            cnt_r  <= (rd_i && !rdy_o) ? cnt_r + 4'h1 : 4'h0;
        end
    end
endmodule

// *** tb/ieau_top_sva.sv ***
module ieau_top_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        start_i,
    input wire logic [7:0]  indexed_postbyte_i,
    input wire logic [7:0]  ext_hi_i,
    input wire logic [7:0]  ext_lo_i,
    input wire logic [15:0] x_i,
    input wire logic [15:0] y_i,
    input wire logic [15:0] sp_i,
    input wire logic [15:0] pc_next_i,
    input wire logic [7:0]  acc_a_i,
    input wire logic [7:0]  acc_b_i,
    input wire logic        load_first_index_effective_address_i,
    input wire logic        load_second_index_effective_address_i,
    input wire logic        load_stack_pointer_effective_address_i,
    input wire logic        mem_rdy_i,
    input wire logic        mem_rd_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic [15:0] ea_o,
    input wire logic        wb_en_o,
    input wire logic [1:0]  wb_sel_o,
    input wire logic [15:0] wb_data_o,
    input wire logic        illegal_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [7:0]  pb  = indexed_postbyte_i;
    wire [1:0]  rr  = pb[4:3];
    wire [1:0]  ra  = pb[7:6];
    wire [15:0] bl  = rr == 2'b00 ? x_i : rr == 2'b01 ? y_i : rr == 2'b10 ? sp_i : pc_next_i;
    wire [15:0] ba  = ra == 2'b00 ? x_i : ra == 2'b01 ? y_i : sp_i;
    wire [15:0] nb  = ba + (pb[3] ? {12'hfff, pb[3:0]} : {13'h0, pb[2:0]} + 16'h0001);
    wire [15:0] dd  = {acc_a_i, acc_b_i};
    wire [15:0] n9  = bl + {{8{pb[0]}}, ext_lo_i};
    wire [15:0] sac = bl + (pb[1:0] == 2'b00 ? {8'h00, acc_a_i} : pb[1:0] == 2'b01 ? {8'h00, acc_b_i} : dd);
    wire [15:0] sin = bl + (pb[2] ? dd : {ext_hi_i, ext_lo_i});
    wire        lng = start_i && !busy_o && pb[7:5] == 3'b111;
    wire        aut = start_i && !busy_o && pb[5] && ra != 2'b11;
    wire        own = ra == 2'b00 ? load_first_index_effective_address_i :
                      ra == 2'b01 ? load_second_index_effective_address_i : load_stack_pointer_effective_address_i;
    AST_NINE: assert property (lng && pb[2:1] == 2'b00 |=> done_o && !wb_en_o && ea_o == $past(n9))
        else $error("nine-bit offset address wrong");
    AST_LONG: assert property (lng && pb[2:0] == 3'b010 |=> done_o && ea_o == $past(sin))
        else $error("long offset address wrong");
    AST_ACC: assert property (lng && pb[2] && pb[1:0] != 2'b11 |=> done_o && !wb_en_o && ea_o == $past(sac))
        else $error("accumulator offset address wrong");
    AST_PTR: assert property (lng && pb[1:0] == 2'b11 |=> mem_rd_o && busy_o && mem_addr_o == $past(sin))
        else $error("pointer fetch address wrong");
    AST_PAIR: assert property (mem_rd_o && mem_rdy_i |=> done_o || mem_addr_o == $past(mem_addr_o) + 16'h0001)
        else $error("second pointer byte address wrong");
    AST_PRE: assert property (aut && !pb[4] |=> done_o && wb_en_o && ea_o == $past(nb) && wb_data_o == ea_o)
        else $error("pre-modify result wrong");
    AST_POST: assert property (aut && pb[4] && !own |=> ea_o == $past(ba) && wb_data_o == $past(nb) && wb_sel_o == $past(ra))
        else $error("post-modify result wrong");
    AST_LEA: assert property (aut && pb[4] && own |=> wb_en_o && wb_data_o == $past(ba))
        else $error("load-address write-back wrong");
    AST_NOPC: assert property (done_o && wb_en_o |-> wb_sel_o != 2'b11)
        else $error("program counter written back");
    AST_ILL: assert property (start_i && !busy_o && !pb[5] |=> done_o && illegal_o && !wb_en_o)
        else $error("short offset form not refused");
    cover property (lng && pb[1:0] == 2'b11);
    cover property (aut && pb[4]);
    cover property (mem_rd_o && mem_rdy_i);
endmodule
bind ieau_top ieau_top_sva sva (.*);

// *** tb/indexed_effective_address_unit_test.sv ***
module indexed_effective_address_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, start_i = 0, mem_rdy_i, mem_rd_o, busy_o, done_o, wb_en_o, illegal_o;
    logic        load_first_index_effective_address_i = 0, load_second_index_effective_address_i = 0;
    logic        load_stack_pointer_effective_address_i = 0;
    logic [7:0]  indexed_postbyte_i = 0, ext_hi_i = 0, ext_lo_i = 0, acc_a_i = 8'hf0, acc_b_i = 8'h81, mem_rdata_i;
    logic [15:0] x_i = 16'h1000, y_i = 16'h2000, sp_i = 16'h3000, pc_next_i = 16'h4000, mem_addr_o, ea_o, wb_data_o;
    logic [1:0]  wb_sel_o;
    logic [3:0]  lat = 0;
    int          err_total = 0, samples_checked = 0;
    always #2.5 clk_i = ~clk_i;
    ieau_top dut (.*);
    ieau_mem mem (.clk_i(clk_i), .rst_i(rst_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o), .lat_i(lat),
                  .rdy_o(mem_rdy_i), .data_o(mem_rdata_i));
    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[15:8] + {a[6:0], 1'b1};
    endfunction
    function automatic logic [15:0] base(input logic [1:0] r);
        return r == 0 ? x_i : r == 1 ? y_i : r == 2 ? sp_i : pc_next_i;
    endfunction
    // Waits for done under a bound, so a silent design cannot hang the run
    task automatic run(input logic [7:0] p, input logic [7:0] h, input logic [7:0] l);
        int n;
        @(negedge clk_i);
        indexed_postbyte_i = p;
        ext_hi_i = h;
        ext_lo_i = l;
        start_i = 1;
        @(negedge clk_i);
        start_i = 0;
        n = 0;
        while (done_o !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        check(16'(n < 50), 16'h0001);
    endtask
    task automatic t_const;
        logic [2:0] f;
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 6; k++) begin
                f = k < 3 ? 3'(k) : 3'(k + 1);
                run({3'b111, r[1:0], f}, 8'hff, k == 1 ? 8'h00 : 8'hff);
                check(ea_o, base(r[1:0]) + (f == 0 ? 16'h00ff : f == 1 ? 16'hff00 : f == 2 ? 16'hffff :
                    f == 4 ? {8'h00, acc_a_i} : f == 5 ? {8'h00, acc_b_i} : {acc_a_i, acc_b_i}));
                check({14'h0, illegal_o, wb_en_o}, 16'h0000);
            end
        end
    endtask
    task automatic t_ind;
        logic [15:0] s;
        x_i = 16'hfff0;
        acc_a_i = 8'h00;
        acc_b_i = 8'h0f;
        s = 16'hffff;
        for (int k = 0; k < 4; k++) begin
            lat = k[1] ? 4'h3 : 4'h0;
            run({5'b11100, k[0], 2'b11}, 8'h00, 8'h0f);
            check(ea_o, {mem_byte(s), mem_byte(s + 16'h0001)});
        end
    endtask
    task automatic t_ill;
        for (int k = 0; k < 2; k++) begin
            run(k[0] ? 8'hd0 : 8'h0f, 8'h00, 8'h00);
            check({14'h0, illegal_o, wb_en_o}, 16'h0002);
        end
    endtask
    task automatic t_auto;
        logic [15:0] b, s;
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 32; k++) begin
                b = base(r[1:0]);
                s = k[3] ? {12'hfff, k[3:0]} : {13'h0, k[2:0]} + 16'h0001;
                run({r[1:0], 1'b1, k[4], k[3:0]}, 8'h00, 8'h00);
                check(ea_o, k[4] ? b : b + s);
                check(wb_data_o, b + s);
                check({13'h0, wb_en_o, wb_sel_o}, {13'h0, 1'b1, r[1:0]});
            end
        end
    endtask
    task automatic t_lea;
        logic [15:0] b;
        for (int k = 0; k < 6; k++) begin
            load_first_index_effective_address_i = k[2:1] == 0;
            load_second_index_effective_address_i = k[2:1] == 1;
            load_stack_pointer_effective_address_i = k[2:1] == 2;
            b = base(k[2:1]);
            run({k[2:1], 1'b1, k[0], 4'h1}, 8'h00, 8'h00);
            check(wb_data_o, k[0] ? b : b + 16'h0002);
        end
        load_first_index_effective_address_i = 0;
        load_second_index_effective_address_i = 0;
        load_stack_pointer_effective_address_i = 0;
    endtask
    initial begin
        #50us;
        err_total++;
        summarize();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        rst_i = 0;
        t_const();
        t_auto();
        t_lea();
        t_ill();
        t_ind();
        summarize();
    end
endmodule
